/* File: bench/rms_sample_accumulator_tb_top.sv */
// bench for the rms sample accumulator
`timescale 1ns/100ps
module rms_sample_accumulator_tb_top;
    import rsa_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic rms_ready = 1'b1;
    logic conv_valid, conv_ready, rms_valid, rms_buf_odd;
    logic [7:0] conv_hi, conv_lo;
    logic [ROOT_W-1:0] rms_value;
    int failures = 0, n_tests = 0, cyc = 0;
    ////////////////////////////////////////
    rsa_top dut (.mclk(mclk), .rst(rst), .conv_valid(conv_valid), .conv_ready(conv_ready),
        .conv_hi(conv_hi), .conv_lo(conv_lo), .rms_value(rms_value), .rms_valid(rms_valid),
        .rms_buf_odd(rms_buf_odd), .rms_ready(rms_ready));
    rsa_conv_model conv (.mclk(mclk), .rst(rst), .conv_valid(conv_valid), .conv_hi(conv_hi), .conv_lo(conv_lo));
    // clock, and a cycle ceiling against hangs
    initial forever #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            summarize();
        end
    end
    // one compare for every result kind
    task automatic chk(input string what, input logic [11:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // floor of the root of a buffer of equal samples
    function automatic logic [11:0] exp_rms(input int s);
        int r = 0;
        while ((r + 1) * (r + 1) <= (SAMPLE_COUNT + 1) * ((s * s) >> DIV_SHIFT))
            r++;
        return 12'(r);
    endfunction
    task automatic t_reset();
        chk("conv_ready", 12'h001, 12'(conv_ready));
        chk("rms_valid", 12'h000, 12'(rms_valid));
        chk("rms_value", 12'h000, rms_value);
        $display("reset test done");
    endtask
    // hold the receiver off, then take one result
    task automatic t_result(input logic odd, input logic [7:0] s, input int hold);
        int n = 0;
        rms_ready = (hold == 0);
        repeat (hold) @(negedge mclk);
        rms_ready = 1'b1;
        while (rms_valid !== 1'b1 && n < 6000) begin
            @(negedge mclk);
            n++;
        end
        chk("rms_valid", 12'h001, 12'(rms_valid));
        chk("rms_value", exp_rms(s), rms_value);
        chk("rms_buf_odd", 12'(odd), 12'(rms_buf_odd));
        @(negedge mclk);
        $display("result test done");
    endtask
    // hold the receiver off until the intake refuses, then take the two waiting results
    task automatic t_stall();
        int n = 0;
        rms_ready = 1'b0;
        while (conv_ready !== 1'b0 && n < 10000) begin
            @(negedge mclk);
            n++;
        end
        chk("conv_ready", 12'h000, 12'(conv_ready));
        $display("stall test done");
        t_result(1'b0, 8'hff, 0);
        t_result(1'b1, 8'h10, 0);
    endtask
    // reset, then four buffers in turn
    initial begin
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        t_reset();
        t_result(1'b0, 8'hff, 0);
        t_result(1'b1, 8'h10, 0);
        t_result(1'b0, 8'hff, 4400);
        t_result(1'b1, 8'h10, 0);
        t_stall();
        summarize();
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
endmodule

/* File: bench/rsa_conv_model.sv */
// converter model: endless results, one rising edge each
`timescale 1ns/100ps
module rsa_conv_model (
    input wire logic mclk, // clock
    input wire logic rst, // reset
    output logic conv_valid = 1'b0, // result edge
    output logic [7:0] conv_hi = 8'h00, // high register
    output logic [7:0] conv_lo = 8'h00 // low register
);
    int k = 0;
    int ph = 0;
    // 8 cycle period, shortened; kept slots carry 8'hff or 8'h10 per 512 edges, dropped ones the inverse
    always @(negedge mclk) begin
        if (rst) begin
            ph <= 0;
            k <= 0;
        end else begin
            ph <= (ph + 1) % 8;
            conv_valid <= (ph < 4);
            if (ph == 0) begin
                k <= k + 1;
                conv_hi <= (((k / 512) % 2 == 1) ? 8'h10 : 8'hff) ^ ((k % 8 == 0) ? 8'h00 : 8'hff);
                conv_lo <= k[7:0];
            end
            // high register data is not held past its window
            if (ph == 4)
                conv_hi <= ~conv_hi;
        end
    end
endmodule

/* File: bench/rsa_top_monitor.sv */
// checker of the rms accumulator result rules
`timescale 1ns/100ps
module rsa_top_monitor (
    input wire logic mclk, // clock
    input wire logic rst, // reset
    input wire logic conv_ready, // intake open
    input wire logic [rsa_pkg::ROOT_W-1:0] rms_value, // result
    input wire logic rms_valid, // result strobe
    input wire logic rms_buf_odd, // source buffer
    input wire logic rms_ready // receiver ready
);
    import rsa_pkg::*;
    ////////////////////////////////////////
    // last source buffer, so alternation can be judged
    logic seen, last_odd;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            seen <= 1'b0;
            last_odd <= 1'b0;
        end else if (rms_valid) begin
            seen <= 1'b1;
            last_odd <= rms_buf_odd;
        end
    end
    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);
    // strobe high for exactly one cycle
    sequence s_pulse;
        rms_valid ##1 !rms_valid;
    endsequence
    chk_strobe_one: assert property (rms_valid |-> s_pulse) else $error("strobe too long");
    chk_strobe_ready: assert property (rms_valid |-> $past(rms_ready)) else $error("strobe unasked");
    chk_value_hold: assert property ($changed(rms_value) |-> rms_valid) else $error("value moved");
    chk_buf_hold: assert property ($changed(rms_buf_odd) |-> rms_valid) else $error("buffer moved");
    chk_first_even: assert property (rms_valid && !seen |-> !rms_buf_odd) else $error("odd first");
    chk_buf_alt: assert property (rms_valid && seen |-> rms_buf_odd != last_odd) else $error("no swap");
    chk_root_range: assert property (rms_valid |-> rms_value < 12'h100) else $error("root too big");
    chk_reset_state: assert property ($fell(rst) |-> conv_ready && rms_value == 12'h000) else $error("bad reset");
endmodule
bind rsa_top rsa_top_monitor mon (.mclk(mclk), .rst(rst), .conv_ready(conv_ready), .rms_value(rms_value),
    .rms_valid(rms_valid), .rms_buf_odd(rms_buf_odd), .rms_ready(rms_ready));

/* File: shared/rsa_pkg.sv */
// shared constants and types of the rms sample accumulator
package rsa_pkg;
    // conversion period of the sampling source
    localparam int CONV_PERIOD_NS = 450000;
    localparam int CLK_PERIOD_NS = 100;
    // cycles between two conversion results, rounded down
    localparam int CONV_PERIOD_CYC = CONV_PERIOD_NS / CLK_PERIOD_NS;
    // decimation: keep one result of this many
    localparam int DECIM_FACTOR = 8;
    // buffer count parameter is samples minus one
    localparam int SAMPLE_COUNT = 63;
    localparam int DIV_SHIFT = 6;
    // longest allowed evaluation time at the reference clock
    localparam int EVAL_LIMIT_US = 14000;
    localparam int REF_CLK_KHZ = 5500;
    localparam int EVAL_LIMIT_CYC = (EVAL_LIMIT_US * REF_CLK_KHZ) / 1000;
    // converter result width, high and low registers
    localparam int RES_HI_W = 8;
    localparam int RES_LO_W = 8;
    localparam int SAMPLE_W = 8;
    localparam int SUM_W = 24;
    localparam int ROOT_W = 12;
    // reset values
    localparam logic [ROOT_W-1:0] ROOT_RESET = 12'h000;
    localparam logic [SUM_W-1:0] SUM_RESET = 24'h000000;

    typedef enum {
        RSA_IDLE,
        RSA_ACCUM,
        RSA_ROOT,
        RSA_DONE
    } rsa_state_t;
endpackage

/* File: src/rsa_top.sv */
// rms sample accumulator: decimate, buffer, square, sum, root
// How it works
// - the converter runs continuously and hands over one result roughly every 450 us on conv_valid.
// - only one result in each group of decim_factor is kept; the others are dropped.
// - each computation cycle gathers 64 kept samples before the rms of that set is evaluated.
// - the sample count parameter is samples minus one and the divide shift is log2 of the samples.
// - each kept result has its high and low register contents reduced to one byte before storage.
// - packed bytes fill an even buffer and an odd buffer in turn, so one fills while the other is used.
// - each buffer holds a power of two entries so that the division is a right shift.
// - the computation reads even and odd buffers in alternation, one full buffer per result.
// - every stored sample is squared, shifted right by the divide shift and added to the running sum.
// - after the last entry the square root of the sum is taken and presented as the result.
// - one evaluation takes far less than 14 ms worth of cycles at 5.5 MHz.
// - decimation factor, sample count and divide shift are build time parameters.
`timescale 1ns/100ps
module rsa_top #(
    parameter int decim_factor = rsa_pkg::DECIM_FACTOR, // kept one of this many
    parameter int sample_count = rsa_pkg::SAMPLE_COUNT, // samples per buffer minus one
    parameter int divide_shift_amount = rsa_pkg::DIV_SHIFT // log2 of samples
) (
    input wire logic mclk, // system clock, 10 MHz
    input wire logic rst, // asynchronous reset, active high
    input wire logic conv_valid, // converter result present
    output logic conv_ready, // buffer can take a result
    input wire logic [rsa_pkg::RES_HI_W-1:0] conv_hi, // result high register
    input wire logic [rsa_pkg::RES_LO_W-1:0] conv_lo, // result low register
    output logic [rsa_pkg::ROOT_W-1:0] rms_value, // last rms result
    output logic rms_valid, // one-cycle strobe on a new result
    output logic rms_buf_odd, // buffer the result came from
    input wire logic rms_ready // receiver takes rms_value
);
    import rsa_pkg::*;

    // throughput: a buffer is worked off in about 80 cycles but takes 64 kept
    // results to fill, so filling only stalls when the receiver holds rms_ready
    // low for a whole fill time; the skid then drops results
    // derived sizes
    localparam int DEPTH = sample_count + 1;
    localparam int IDX_W = $clog2(DEPTH);
    localparam int DCW = $clog2(decim_factor) + 1;

    ////////////////////////////////////////////////////////////////
    // state record
    typedef struct packed {
        logic [1:0] sync_v; // converter valid, two stages
        logic [RES_HI_W+RES_LO_W-1:0] sync_d0; // first data stage
        logic [RES_HI_W+RES_LO_W-1:0] sync_d1; // second data stage
        logic sync_v_prev; // edge detect on second stage
        logic [1:0][SAMPLE_W-1:0] sk_data; // two-entry skid buffer
        logic [1:0] sk_full;
        logic sk_rd;
        logic sk_wr;
        logic [DCW-1:0] decim_cnt;
        logic [1:0][DEPTH-1:0][SAMPLE_W-1:0] bufs;
        logic [1:0][IDX_W:0] fill; // fill pointers
        logic [1:0] ready_buf; // buffer complete, waiting
        logic fill_sel; // buffer being filled
        logic calc_sel; // buffer being computed
        rsa_state_t state;
        logic [IDX_W:0] rd_idx;
        logic [SUM_W-1:0] sum;
        logic [ROOT_W-1:0] root;
        logic [ROOT_W-1:0] bit_probe;
        logic [ROOT_W-1:0] rms_value;
        logic rms_valid;
        logic rms_buf_odd;
        logic conv_ready;
    } rsa_regs_t;

    rsa_regs_t r;
    rsa_regs_t next_r;

    // reduce a converter pair to one byte: top bits of the combined word
    function automatic logic [SAMPLE_W-1:0] pack_byte(input logic [RES_HI_W+RES_LO_W-1:0] w);
        return w[RES_HI_W+RES_LO_W-1 -: SAMPLE_W];
    endfunction

    // square one byte and divide by the sample count
    function automatic logic [SUM_W-1:0] scaled_square(input logic [SAMPLE_W-1:0] s);
        logic [2*SAMPLE_W-1:0] sq;
        sq = s * s;
        return SUM_W'(sq >> divide_shift_amount);
    endfunction

    // true on the last entry of a buffer; shared by filling and computing
    function automatic logic last_entry(input logic [IDX_W:0] idx);
        return idx == (IDX_W+1)'(sample_count);
    endfunction

    // skid head and the trial root of the current bit
    logic [SAMPLE_W-1:0] head;
    logic [2*ROOT_W-1:0] trial_sq;
    logic [ROOT_W-1:0] trial;
    assign head = r.sk_data[r.sk_rd];
    assign trial = r.root | r.bit_probe;
    assign trial_sq = trial * trial;

    ////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic take;
        logic pop;
        logic new_edge;
        next_r = r;
        take = 1'b0;
        pop = 1'b0;
        new_edge = 1'b0;
        next_r.rms_valid = 1'b0;
        // valid and data only read after the second stage
        next_r.sync_v = {r.sync_v[0], conv_valid};
        next_r.sync_d0 = {conv_hi, conv_lo};
        next_r.sync_d1 = r.sync_d0;
        next_r.sync_v_prev = r.sync_v[1];
        new_edge = r.sync_v[1] & ~r.sync_v_prev;
        // second data stage lines up with the delayed valid edge
        // decimation, counter advances on every edge, sample kept only on the first of the group
        if (new_edge) begin
            if (r.decim_cnt == DCW'(decim_factor - 1)) begin
                next_r.decim_cnt = '0;
            end else begin
                next_r.decim_cnt = r.decim_cnt + 1'b1;
            end
            take = (r.decim_cnt == '0) && r.conv_ready;
        end
        // skid buffer write; a full buffer drops the sample
        if (take) begin
            next_r.sk_data[r.sk_wr] = pack_byte(r.sync_d1);
            next_r.sk_full[r.sk_wr] = 1'b1;
            next_r.sk_wr = ~r.sk_wr;
        end
        // drain into the filling buffer if it is free
        if (r.sk_full[r.sk_rd] && !r.ready_buf[r.fill_sel]) begin
            pop = 1'b1;
            next_r.bufs[r.fill_sel][r.fill[r.fill_sel][IDX_W-1:0]] = head;
            if (last_entry(r.fill[r.fill_sel])) begin
                next_r.fill[r.fill_sel] = '0;
                next_r.ready_buf[r.fill_sel] = 1'b1;
                next_r.fill_sel = ~r.fill_sel;
            end else begin
                next_r.fill[r.fill_sel] = r.fill[r.fill_sel] + 1'b1;
            end
        end
        if (pop) begin
            next_r.sk_full[r.sk_rd] = 1'b0;
            next_r.sk_rd = ~r.sk_rd;
        end
        // set again after the pop so a new word always wins its slot
        if (take) begin
            next_r.sk_full[r.sk_wr] = 1'b1;
        end
        // from the next fill state, so ready drops with the last free slot
        next_r.conv_ready = ~(next_r.sk_full[0] & next_r.sk_full[1]);
        // computation sequencer
        case (r.state)
            RSA_IDLE: begin
                // start once the current side holds a full buffer
                if (r.ready_buf[r.calc_sel]) begin
                    next_r.sum = SUM_RESET;
                    next_r.rd_idx = '0;
                    next_r.state = RSA_ACCUM;
                end
            end
            RSA_ACCUM: begin
                // one entry per cycle, so 64 cycles a buffer
                next_r.sum = r.sum + scaled_square(r.bufs[r.calc_sel][r.rd_idx[IDX_W-1:0]]);
                if (last_entry(r.rd_idx)) begin
                    next_r.root = '0;
                    next_r.bit_probe = {1'b1, {(ROOT_W-1){1'b0}}};
                    next_r.state = RSA_ROOT;
                end else begin
                    next_r.rd_idx = r.rd_idx + 1'b1;
                end
            end
            RSA_ROOT: begin
                // one result bit per cycle; bounds the run well inside the limit
                // keep the bit while its square still fits under the sum
                if ((2*ROOT_W)'(trial_sq) <= (2*ROOT_W)'(r.sum)) begin
                    next_r.root = trial;
                end
                next_r.bit_probe = r.bit_probe >> 1;
                if (r.bit_probe[0]) begin
                    next_r.state = RSA_DONE;
                end
            end
            RSA_DONE: begin
                // waits for the receiver so no result is overwritten unseen
                if (rms_ready) begin
                    next_r.rms_value = r.root;
                    next_r.rms_valid = 1'b1;
                    next_r.rms_buf_odd = r.calc_sel;
                    next_r.ready_buf[r.calc_sel] = 1'b0;
                    next_r.calc_sel = ~r.calc_sel;
                    next_r.state = RSA_IDLE;
                end
            end
            default: begin
                // unused codes fall back to idle
                next_r.state = RSA_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // register the state record
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            // whole record to zero, then the reset constants and the one non-zero value, conv_ready
            r <= '0;
            r.state <= RSA_IDLE;
            r.sum <= SUM_RESET;
            r.rms_value <= ROOT_RESET;
            r.conv_ready <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state record flip-flops
    assign conv_ready = r.conv_ready;
    assign rms_value = r.rms_value;
    assign rms_valid = r.rms_valid;
    assign rms_buf_odd = r.rms_buf_odd;
endmodule
